/* rtcaw_checker.sv */
// port assertions for the alarm, watchdog and output control block
module rtcaw_checker
  import rtcaw_pkg::*;
#(
  parameter int unsigned WD_UNIT_OSC = 4
) (
  input wire logic                  clock_i,
  input wire logic                  rstn_i,
  input wire rtcaw_pkg::rtcaw_bus_t bus_i,
  input wire logic                  century_roll_i,
  input wire logic [7:0]            rd_data_o,
  input wire logic                  event_pin_o,
  input wire logic                  event_pin_oe_n_o,
  input wire logic                  osc_halt_o,
  input wire logic                  century_flag_o,
  input wire logic                  halt_update_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ceb_r; // century enable as last written
  default clocking cb_ck @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // shadow of the century enable; without it a toggle cannot be judged
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      ceb_r <= 1'b0;
    else if (bus_i.wr && bus_i.ptr == 8'h03)
      ceb_r <= bus_i.wdata[7];
  AST_PWRUP: assert property (
    $rose(rstn_i) |-> osc_halt_o && halt_update_o && event_pin_oe_n_o)
    else $error("power-up defaults wrong");
  AST_PIN_DATA: assert property (
    event_pin_o == 1'b0) else $error("open drain data not low");
  AST_ST_WR: assert property (
    bus_i.wr && bus_i.ptr == 8'h01 |=> osc_halt_o == $past(bus_i.wdata[7]))
    else $error("stop bit not taken");
  AST_HT_WR: assert property (
    bus_i.wr && bus_i.ptr == 8'h0c |=> halt_update_o == $past(bus_i.wdata[6]))
    else $error("halt update bit not taken");
  AST_CB_ROLL: assert property (
    century_roll_i && !bus_i.wr |=>
    (century_flag_o ^ $past(century_flag_o)) == $past(ceb_r))
    else $error("century bit toggle wrong");
  AST_CB_HOLD: assert property (
    !century_roll_i && !(bus_i.wr && bus_i.ptr == 8'h03) |=> $stable(century_flag_o))
    else $error("century bit moved");
  AST_SQW_RD: assert property (
    bus_i.rd && bus_i.ptr == 8'h13 |=> rd_data_o[3:0] == 4'h0)
    else $error("rate byte low bits set");
  AST_FLAG_RD: assert property (
    bus_i.rd && bus_i.ptr == 8'h0f |=> (rd_data_o & 8'h2b) == 8'h00)
    else $error("flags zero bits set");
endmodule // rtcaw_checker

bind rtcaw_ctrl rtcaw_checker #(.WD_UNIT_OSC(WD_UNIT_OSC)) rtcaw_checker_inst (
  .clock_i, .rstn_i, .bus_i, .century_roll_i, .rd_data_o, .event_pin_o,
  .event_pin_oe_n_o, .osc_halt_o, .century_flag_o, .halt_update_o);

/* rtcaw_ctrl.sv */
// alarm, watchdog, square wave, flags and shared event pin control
//
// Behaviour
// - alarm settings held at 0ah through 0eh
// - repeat bits select second to yearly
// - undefined repeat codes act once per second
// - match sets alarm flag, drives pin
// - pointer on flags defers alarm pin
// - flags read clears alarm flag, pin
// - backup alarm needs both enables set
// - watchdog multiplier and resolution fields
// - timeout is multiplier times resolution unit
// - watchdog write restarts the timeout
// - zero write releases pin, disables watchdog
// - flags read clears watchdog flag
// - watchdog beats frequency test on pin
// - rate code selects square wave frequency
// - square wave shown only while enabled
// - century bit toggles when enabled
// - battery check sets low flag
// - oscillator fail flag set conditions
// - oscillator fail flag held until cleared
// - oscillator fail interrupt cleared by writes
// - idle pin follows output level bit
// - power-on defaults of control bits
// - time bcd, control bytes plain binary
// - frequency test toggles pin at 512hz
`include "rtcaw_defs.svh"
module rtcaw_ctrl #(
  parameter int unsigned WD_UNIT_OSC = `RTCAW_WD_UNIT_OSC
) (
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  input  wire logic                 osc_32k_i,
  input  wire logic                 batt_low_i,
  input  wire logic                 backup_mode_i,
  input  wire logic                 osc_fail_det_i,
  input  wire rtcaw_pkg::rtcaw_bus_t  bus_i,
  input  wire rtcaw_pkg::rtcaw_time_t time_i,
  input  wire logic                 sec_tick_i,
  input  wire logic                 century_roll_i,
  input  wire logic                 batt_check_i,
  output logic [7:0]                rd_data_o,
  output logic                      event_pin_o,
  output logic                      event_pin_oe_n_o,
  output logic                      osc_halt_o,
  output logic                      century_flag_o,
  output logic                      halt_update_o
);
  import rtcaw_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  localparam logic [`RTCAW_WD_CNT_W-1:0] WD_UNIT = `RTCAW_WD_CNT_W'(WD_UNIT_OSC);

  function automatic logic is_alarm_addr(input logic [7:0] ptr);
    is_alarm_addr = (ptr >= `RTCAW_ADDR_ALM_MON) && (ptr <= `RTCAW_ADDR_ALM_SEC);
  endfunction

  function automatic logic [2:0] alarm_idx(input logic [7:0] ptr);
    logic [7:0] diff;
    diff = ptr - `RTCAW_ADDR_ALM_MON;
    alarm_idx = diff[2:0];
  endfunction

  // five repeat bits to mode; any other code falls back to per second
  function automatic rtcaw_rpt_t rpt_decode(input logic [4:0] rpt);
    case (rpt)
      5'b11111: rpt_decode = RPT_SEC;
      5'b11110: rpt_decode = RPT_MIN;
      5'b11100: rpt_decode = RPT_HOUR;
      5'b11000: rpt_decode = RPT_DAY;
      5'b10000: rpt_decode = RPT_MONTH;
      5'b00000: rpt_decode = RPT_YEAR;
      default:  rpt_decode = RPT_SEC;
    endcase
  endfunction

  // timeout length in oscillator cycles: multiplier times 4**res units
  function automatic logic [`RTCAW_WD_CNT_W-1:0] wd_limit(input logic [4:0] mult,
                                                      input logic [1:0] res);
    logic [`RTCAW_WD_CNT_W-1:0] unit;
    unit = WD_UNIT << {res, 1'b0};
    wd_limit = `RTCAW_WD_CNT_W'(unit * mult);
  endfunction

  // ------------------------------------------------------------
  // input synchronisation and oscillator edge
  // ------------------------------------------------------------
  logic [`RTCAW_SYNC_W-1:0] sync_s;
  logic                     osc_prev_r;
  logic                     osc_s;
  logic                     batt_low_s;
  logic                     backup_s;
  logic                     osc_fail_s;
  logic                     osc_tick;

  rtcaw_sync u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({osc_fail_det_i, backup_mode_i, batt_low_i, osc_32k_i}),
    .sync_o  (sync_s)
  );

  assign osc_s      = sync_s[0];
  assign batt_low_s = sync_s[1];
  assign backup_s   = sync_s[2];
  assign osc_fail_s = sync_s[3];

  // edge of the synchronised oscillator; a stopped oscillator gives no ticks
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= osc_s;
  end

  logic st_r;
  assign osc_tick = osc_s & ~osc_prev_r & ~st_r;

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0] cal_r;
  logic [7:0] wd_r;
  logic [7:0] sqw_r;
  logic [7:0] alm_r [`RTCAW_ALM_N];
  logic       ceb_r;
  logic       cb_r;
  logic       wr_sec;
  logic       wr_hour;
  logic       wr_cal;
  logic       wr_wd;
  logic       wr_flags;
  logic       rd_flags;

  assign wr_sec   = bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_SEC);
  assign wr_hour  = bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_HOUR);
  assign wr_cal   = bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_CAL);
  assign wr_wd    = bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_WDOG);
  assign wr_flags = bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_FLAGS);
  assign rd_flags = bus_i.rd && (bus_i.ptr == `RTCAW_ADDR_FLAGS);

  // plain binary control bytes; power-on leaves the output level high
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cal_r <= `RTCAW_CAL_RST;
      wd_r  <= `RTCAW_WDOG_RST;
      sqw_r <= `RTCAW_SQW_RST;
    end
    else
    begin
      if (wr_cal)
        cal_r <= bus_i.wdata;
      if (wr_wd)
        wd_r <= bus_i.wdata;
      if (bus_i.wr && (bus_i.ptr == `RTCAW_ADDR_SQW))
        sqw_r <= {bus_i.wdata[`RTCAW_RS_HI:`RTCAW_RS_LO], 4'h0};
    end
  end

  // alarm bank; the hour slot also carries the halt update bit
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < `RTCAW_ALM_N; i++)
        alm_r[i] <= `RTCAW_ALM_RST;
      alm_r[`RTCAW_IDX_HOUR] <= `RTCAW_ALM_HOUR_RST;
    end
    else if (bus_i.wr && is_alarm_addr(bus_i.ptr))
      alm_r[alarm_idx(bus_i.ptr)] <= bus_i.wdata;
  end

  // stop bit and century pair; a rollover is applied after a same-cycle write
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r  <= 1'b1;
      ceb_r <= 1'b0;
      cb_r  <= 1'b0;
    end
    else
    begin
      if (wr_sec)
        st_r <= bus_i.wdata[`RTCAW_ST_BIT];
      if (wr_hour)
      begin
        ceb_r <= bus_i.wdata[`RTCAW_CEB_BIT];
        cb_r  <= bus_i.wdata[`RTCAW_CB_BIT] ^ (century_roll_i & bus_i.wdata[`RTCAW_CEB_BIT]);
      end
      else if (century_roll_i && ceb_r)
        cb_r <= ~cb_r;
    end
  end

  // ------------------------------------------------------------
  // alarm match and flag
  // ------------------------------------------------------------
  rtcaw_rpt_t rpt_mode;
  logic       m_sec;
  logic       m_min;
  logic       m_hour;
  logic       m_date;
  logic       m_mon;
  logic       alarm_hit;
  logic       af_r;

  assign rpt_mode = rpt_decode({alm_r[`RTCAW_IDX_DATE][`RTCAW_RPT5_BIT],
                                alm_r[`RTCAW_IDX_DATE][`RTCAW_RPT_BIT],
                                alm_r[`RTCAW_IDX_HOUR][`RTCAW_RPT_BIT],
                                alm_r[`RTCAW_IDX_MIN][`RTCAW_RPT_BIT],
                                alm_r[`RTCAW_IDX_SEC][`RTCAW_RPT_BIT]});

  // bcd fields compared with the control bits masked off
  assign m_sec  = (alm_r[`RTCAW_IDX_SEC] & `RTCAW_MSK_SEC) == (time_i.sec & `RTCAW_MSK_SEC);
  assign m_min  = (alm_r[`RTCAW_IDX_MIN] & `RTCAW_MSK_SEC) == (time_i.min & `RTCAW_MSK_SEC);
  assign m_hour = (alm_r[`RTCAW_IDX_HOUR] & `RTCAW_MSK_HOUR) == (time_i.hour & `RTCAW_MSK_HOUR);
  assign m_date = (alm_r[`RTCAW_IDX_DATE] & `RTCAW_MSK_DATE) == (time_i.date & `RTCAW_MSK_DATE);
  assign m_mon  = (alm_r[`RTCAW_IDX_MON] & `RTCAW_MSK_MON) == (time_i.month & `RTCAW_MSK_MON);

  // matches are judged only on the second tick, so each match fires once
  always_comb
  begin
    unique case (rpt_mode)
      RPT_SEC:   alarm_hit = sec_tick_i;
      RPT_MIN:   alarm_hit = sec_tick_i & m_sec;
      RPT_HOUR:  alarm_hit = sec_tick_i & m_sec & m_min;
      RPT_DAY:   alarm_hit = sec_tick_i & m_sec & m_min & m_hour;
      RPT_MONTH: alarm_hit = sec_tick_i & m_sec & m_min & m_hour & m_date;
      RPT_YEAR:  alarm_hit = sec_tick_i & m_sec & m_min & m_hour & m_date & m_mon;
      default:   alarm_hit = 1'b0;
    endcase
  end

  // a new match wins over a flags read in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      af_r <= 1'b0;
    else if (alarm_hit)
      af_r <= 1'b1;
    else if (rd_flags)
      af_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  logic [`RTCAW_WD_CNT_W-1:0] wd_cnt_r;
  logic [`RTCAW_WD_CNT_W-1:0] wd_cnt_inc;
  logic [4:0]                 wd_mult;
  logic                       wd_timeout;
  logic                       wd_irq_r;
  logic                       wdf_r;

  assign wd_mult    = wd_r[`RTCAW_MULT_HI:`RTCAW_MULT_LO];
  assign wd_cnt_inc = wd_cnt_r + 1'b1;
  assign wd_timeout = osc_tick && !wr_wd && !wd_irq_r && (wd_mult != 5'h00) &&
                      (wd_cnt_inc == wd_limit(wd_mult, wd_r[`RTCAW_RES_HI:`RTCAW_RES_LO]));

  // counter parks after a timeout until a zero write to the register clears the interrupt
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wd_cnt_r <= '0;
    else if (wr_wd)
      wd_cnt_r <= '0;
    else if (wd_timeout)
      wd_cnt_r <= '0;
    else if (osc_tick && !wd_irq_r && (wd_mult != 5'h00))
      wd_cnt_r <= wd_cnt_inc;
  end

  // only a zero write releases the pin; a zero multiplier also stops counting
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wd_irq_r <= 1'b0;
    else if (wr_wd && (bus_i.wdata == 8'h00))
      wd_irq_r <= 1'b0;
    else if (wd_timeout)
      wd_irq_r <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wdf_r <= 1'b0;
    else if (wd_timeout)
      wdf_r <= 1'b1;
    else if (rd_flags)
      wdf_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // battery low and oscillator fail flags
  // ------------------------------------------------------------
  logic [1:0] pwrup_cnt_r;
  logic       bl_r;
  logic       of_r;

  // power-up check waits for the synchroniser to fill
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pwrup_cnt_r <= `RTCAW_PWRUP_DLY;
    else if (pwrup_cnt_r != 2'h0)
      pwrup_cnt_r <= pwrup_cnt_r - 2'h1;
  end

  // requested checks only run on main supply, the power-up check always; the flag holds between checks
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bl_r <= 1'b0;
    else if ((pwrup_cnt_r == `RTCAW_PWRUP_CHK) || (batt_check_i && !backup_s))
      bl_r <= batt_low_s;
  end

  // set conditions win over a clearing write
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      of_r <= 1'b1;
    else if (st_r || osc_fail_s)
      of_r <= 1'b1;
    else if (wr_flags && !bus_i.wdata[`RTCAW_OF_BIT])
      of_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // square wave divider
  // ------------------------------------------------------------
  logic [`RTCAW_DIV_W-1:0] div_r;
  logic [3:0]              rate;
  logic [3:0]              rate_idx;
  logic                    sqw_lvl;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_r <= '0;
    else if (osc_tick)
      div_r <= div_r + 1'b1;
  end

  // code 1 passes the oscillator itself, code n taps divider stage n-1
  assign rate     = sqw_r[`RTCAW_RS_HI:`RTCAW_RS_LO];
  assign rate_idx = rate - `RTCAW_RS_FULL;
  assign sqw_lvl  = (rate == `RTCAW_RS_FULL) ? osc_s : div_r[rate_idx];

  // ------------------------------------------------------------
  // shared event pin
  // ------------------------------------------------------------
  logic afe;
  logic square_wave_enable;
  logic abe;
  logic oscfail_irq_enable;
  logic alarm_act;
  logic irq_any;
  logic drive_low;
  logic pin_drive_r;

  assign afe  = alm_r[`RTCAW_IDX_MON][`RTCAW_AFE_BIT];
  assign square_wave_enable = alm_r[`RTCAW_IDX_MON][`RTCAW_SQUARE_WAVE_ENABLE_BIT];
  assign abe  = alm_r[`RTCAW_IDX_MON][`RTCAW_ABE_BIT];
  assign oscfail_irq_enable = wd_r[`RTCAW_OSCFAIL_IRQ_ENABLE_BIT];

  // alarm request waits while the pointer rests on the flags register
  assign alarm_act = af_r && afe && !square_wave_enable &&
                     (bus_i.ptr != `RTCAW_ADDR_FLAGS) &&
                     (!backup_s || abe);
  assign irq_any   = alarm_act | wd_irq_r | (oscfail_irq_enable & of_r);

  // priority: backup, square wave, interrupts, test, output level
  always_comb
  begin
    drive_low = 1'b0;
    if (backup_s)
      drive_low = alarm_act;
    else if (square_wave_enable)
      drive_low = (rate != 4'h0) && !sqw_lvl;
    else if (irq_any)
      drive_low = 1'b1;
    else if (afe || (wd_r != 8'h00) || oscfail_irq_enable)
      drive_low = 1'b0;
    else if (cal_r[`RTCAW_FT_BIT])
      drive_low = !st_r && !div_r[`RTCAW_FT_DIV_BIT];
    else
      drive_low = !cal_r[`RTCAW_OUT_BIT];
  end

  // registered so the pin never glitches through the mux
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pin_drive_r <= 1'b0;
    else
      pin_drive_r <= drive_low;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [7:0] rd_nxt;
  logic [7:0] flags;
  logic [7:0] rd_data_r;

  always_comb
  begin
    flags                  = 8'h00;
    flags[`RTCAW_WDF_BIT]  = wdf_r;
    flags[`RTCAW_AF_BIT]   = af_r;
    flags[`RTCAW_BL_BIT]   = bl_r;
    flags[`RTCAW_OF_BIT]   = of_r;
  end

  // reserved and unmapped locations read as zero
  always_comb
  begin
    rd_nxt = 8'h00;
    if (is_alarm_addr(bus_i.ptr))
      rd_nxt = alm_r[alarm_idx(bus_i.ptr)];
    else
      case (bus_i.ptr)
        `RTCAW_ADDR_HUND:  rd_nxt = time_i.hund;
        `RTCAW_ADDR_SEC:   rd_nxt = {st_r, time_i.sec[6:0]};
        `RTCAW_ADDR_MIN:   rd_nxt = time_i.min;
        `RTCAW_ADDR_HOUR:  rd_nxt = {ceb_r, cb_r, time_i.hour[5:0]};
        `RTCAW_ADDR_DAY:   rd_nxt = time_i.day;
        `RTCAW_ADDR_DATE:  rd_nxt = time_i.date;
        `RTCAW_ADDR_MONTH: rd_nxt = time_i.month;
        `RTCAW_ADDR_YEAR:  rd_nxt = time_i.year;
        `RTCAW_ADDR_CAL:   rd_nxt = cal_r;
        `RTCAW_ADDR_WDOG:  rd_nxt = wd_r;
        `RTCAW_ADDR_FLAGS: rd_nxt = flags;
        `RTCAW_ADDR_SQW:   rd_nxt = sqw_r;
        default:           rd_nxt = 8'h00;
      endcase
  end

  // data captured on the read strobe and held until the next read
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rd_data_r <= 8'h00;
    else if (bus_i.rd)
      rd_data_r <= rd_nxt;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rd_data_o        = rd_data_r;
  assign event_pin_o      = 1'b0;
  assign event_pin_oe_n_o = ~pin_drive_r;
  assign osc_halt_o       = st_r;
  assign century_flag_o   = cb_r;
  assign halt_update_o    = alm_r[`RTCAW_IDX_HOUR][`RTCAW_HT_BIT];

endmodule // rtcaw_ctrl

/* rtcaw_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef RTCAW_DEFS_SVH
`define RTCAW_DEFS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define RTCAW_ADDR_HUND     8'h00
`define RTCAW_ADDR_SEC      8'h01
`define RTCAW_ADDR_MIN      8'h02
`define RTCAW_ADDR_HOUR     8'h03
`define RTCAW_ADDR_DAY      8'h04
`define RTCAW_ADDR_DATE     8'h05
`define RTCAW_ADDR_MONTH    8'h06
`define RTCAW_ADDR_YEAR     8'h07
`define RTCAW_ADDR_CAL      8'h08
`define RTCAW_ADDR_WDOG     8'h09
`define RTCAW_ADDR_ALM_MON  8'h0a
`define RTCAW_ADDR_ALM_SEC  8'h0e
`define RTCAW_ADDR_FLAGS    8'h0f
`define RTCAW_ADDR_SQW      8'h13

// ------------------------------------------------------------
// bit positions
// ------------------------------------------------------------
`define RTCAW_ST_BIT    7
`define RTCAW_CEB_BIT   7
`define RTCAW_CB_BIT    6
`define RTCAW_OUT_BIT   7
`define RTCAW_FT_BIT    6
`define RTCAW_OSCFAIL_IRQ_ENABLE_BIT  7
`define RTCAW_AFE_BIT   7
`define RTCAW_SQUARE_WAVE_ENABLE_BIT  6
`define RTCAW_ABE_BIT   5
`define RTCAW_HT_BIT    6
`define RTCAW_RPT_BIT   7
`define RTCAW_RPT5_BIT  6
`define RTCAW_WDF_BIT   7
`define RTCAW_AF_BIT    6
`define RTCAW_BL_BIT    4
`define RTCAW_OF_BIT    2
`define RTCAW_MULT_HI   6
`define RTCAW_MULT_LO   2
`define RTCAW_RES_HI    1
`define RTCAW_RES_LO    0
`define RTCAW_RS_HI     7
`define RTCAW_RS_LO     4

// ------------------------------------------------------------
// alarm bank indices and bcd compare masks
// ------------------------------------------------------------
`define RTCAW_ALM_N        5
`define RTCAW_IDX_MON      3'h0
`define RTCAW_IDX_DATE     3'h1
`define RTCAW_IDX_HOUR     3'h2
`define RTCAW_IDX_MIN      3'h3
`define RTCAW_IDX_SEC      3'h4
`define RTCAW_MSK_SEC      8'h7f
`define RTCAW_MSK_HOUR     8'h3f
`define RTCAW_MSK_DATE     8'h3f
`define RTCAW_MSK_MON      8'h1f

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RTCAW_CAL_RST      8'h80
`define RTCAW_WDOG_RST     8'h00
`define RTCAW_ALM_RST      8'h00
`define RTCAW_ALM_HOUR_RST 8'h40
`define RTCAW_SQW_RST      8'h00
`define RTCAW_OSC_HZ       32768
`define RTCAW_WD_UNIT_OSC  (`RTCAW_OSC_HZ / 16)
`define RTCAW_WD_CNT_W     23
`define RTCAW_DIV_W        15
`define RTCAW_FT_DIV_BIT   5
`define RTCAW_RS_FULL      4'h1
`define RTCAW_SYNC_W       4
`define RTCAW_PWRUP_DLY    2'h3
`define RTCAW_PWRUP_CHK    2'h1

`endif

/* rtcaw_host.sv */
// host model issuing single byte register reads and writes
module rtcaw_host
  import rtcaw_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic [7:0]      rd_data_i,
  output rtcaw_pkg::rtcaw_bus_t bus_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus_o = '0;
  // write; data turned over afterwards so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    bus_o.ptr = a;
    bus_o.wdata = d;
    bus_o.wr = 1'b1;
    @(negedge clock_i);
    bus_o.wr = 1'b0;
    bus_o.wdata = ~d;
  endtask
  // read; the pointer stays where the read left it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    bus_o.ptr = a;
    bus_o.rd = 1'b1;
    @(negedge clock_i);
    bus_o.rd = 1'b0;
    @(negedge clock_i);
    d = rd_data_i;
  endtask
endmodule // rtcaw_host

/* rtcaw_pkg.sv */
// types shared by the alarm, watchdog and output control block
package rtcaw_pkg;

  // current time from the timekeeping counters, bcd
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
    logic [7:0] hund;
  } rtcaw_time_t;

  // register access from the serial framing logic
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } rtcaw_bus_t;

  // alarm repeat modes
  typedef enum logic [2:0] {
    RPT_SEC   = 3'b000,
    RPT_MIN   = 3'b001,
    RPT_HOUR  = 3'b010,
    RPT_DAY   = 3'b011,
    RPT_MONTH = 3'b100,
    RPT_YEAR  = 3'b101
  } rtcaw_rpt_t;

endpackage

/* rtcaw_sync.sv */
// two-flop synchroniser for the asynchronous inputs
`include "rtcaw_defs.svh"
module rtcaw_sync (
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  input  wire logic [`RTCAW_SYNC_W-1:0] async_i,
  output logic      [`RTCAW_SYNC_W-1:0] sync_o
);

  logic [`RTCAW_SYNC_W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // rtcaw_sync

/* tb.sv */
// self-checking bench for the alarm, watchdog and output control block
module tb;
  import rtcaw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WDU = 4; // short watchdog unit keeps the run brief
  localparam logic [7:0] ALM [5] = '{8'h80, 8'h40, 8'hc0, 8'h80, 8'h85};
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       osc = 1'b0;
  logic       tick = 1'b0;
  logic       roll = 1'b0;
  logic       bkp = 1'b0;
  logic       blow = 1'b0;
  logic       bchk = 1'b0;
  rtcaw_bus_t bus;
  logic [7:0] rd_data;
  logic       pin, oe_n, halt, cent, hu;
  int         err_total = 0;
  int         n_compared = 0;
  int         cnt;
  always #2 clock_i = ~clock_i;
  always #16 osc = ~osc; // 32 ns link timebase
  rtcaw_ctrl #(.WD_UNIT_OSC(WDU)) rtcaw_ctrl_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .osc_32k_i(osc), .batt_low_i(blow),
    .backup_mode_i(bkp), .osc_fail_det_i(1'b0), .bus_i(bus), .time_i('0),
    .sec_tick_i(tick), .century_roll_i(roll), .batt_check_i(bchk),
    .rd_data_o(rd_data), .event_pin_o(pin), .event_pin_oe_n_o(oe_n),
    .osc_halt_o(halt), .century_flag_o(cent), .halt_update_o(hu));
  rtcaw_host rtcaw_host_inst (.clock_i(clock_i), .rd_data_i(rd_data), .bus_o(bus));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    rtcaw_host_inst.wr(a, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rtcaw_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  // pin is registered, so it is looked at one falling edge later
  task automatic pin_is(input logic e);
    @(negedge clock_i);
    chk({7'h00, oe_n}, {7'h00, e});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask
  // pin changes seen at falling edges over a window of w cycles
  task automatic toggles(input int w, output int n);
    logic p;
    @(negedge clock_i);
    p = oe_n;
    n = 0;
    repeat (w)
    begin
      @(negedge clock_i);
      n += int'(oe_n !== p);
      p = oe_n;
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well beyond the few thousand cycles the tests need
  initial
  begin
    #40000;
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    chk_rd(8'h08, 8'h80);
    chk_rd(8'h09, 8'h00);
    chk_rd(8'h0c, 8'h40);
    chk_rd(8'h13, 8'h00);
    chk_rd(8'h0f, 8'h04);
    chk({5'h00, halt, hu, oe_n}, 8'h07);
    // idle pin follows the output level bit
    put(8'h08, 8'h00);
    pin_is(1'b0);
    put(8'h08, 8'h80);
    pin_is(1'b1);
    // watchdog of one short unit, serviced once before it expires
    put(8'h01, 8'h00);
    chk({7'h00, halt}, 8'h00);
    put(8'h0f, 8'h00);
    put(8'h09, 8'h04);
    repeat (20) @(negedge clock_i);
    pin_is(1'b1);
    put(8'h09, 8'h04);
    cnt = 0;
    while (oe_n === 1'b1 && cnt < 400)
    begin
      @(negedge clock_i);
      cnt++;
    end
    chk({7'h00, cnt > (WDU - 1) * 8 && cnt < WDU * 8 + 20}, 8'h01);
    chk_rd(8'h0f, 8'h80);
    chk_rd(8'h0f, 8'h00);
    pin_is(1'b0);
    put(8'h09, 8'h00);
    pin_is(1'b1);
    // unlisted repeat code with a seconds target that never matches
    for (int i = 0; i < 5; i++)
      put(8'h0a + 8'(i), ALM[i]);
    chk_rd(8'h0f, 8'h00);
    pulse(tick);
    repeat (3) @(negedge clock_i);
    pin_is(1'b1);
    chk_rd(8'h08, 8'h80);
    pin_is(1'b0);
    chk_rd(8'h0f, 8'h40);
    chk_rd(8'h08, 8'h80);
    pin_is(1'b1);
    chk_rd(8'h0f, 8'h00);
    // century toggle with the enable set
    put(8'h03, 8'h80);
    pulse(roll);
    chk({7'h00, cent}, 8'h01);
    // oscillator fail interrupt survives a flags read
    put(8'h01, 8'h80);
    put(8'h09, 8'h80);
    chk_rd(8'h0f, 8'h04);
    pin_is(1'b0);
    put(8'h09, 8'h00);
    pin_is(1'b1);
    // second rate gives a 16-cycle half period with the 32 ns timebase
    put(8'h01, 8'h00);
    put(8'h13, 8'h20);
    put(8'h0a, 8'h40);
    toggles(128, cnt);
    chk(8'(cnt), 8'h08);
    put(8'h0a, 8'h00);
    toggles(128, cnt);
    chk(8'(cnt), 8'h00);
    // test output is held off while the watchdog is armed
    put(8'h08, 8'hc0);
    put(8'h09, 8'h7f);
    toggles(1024, cnt);
    chk(8'(cnt), 8'h00);
    put(8'h09, 8'h00);
    toggles(1024, cnt);
    chk(8'(cnt), 8'h04);
    // in back-up only the alarm drives, and only with both enables
    bkp = 1'b1;
    put(8'h0a, 8'h80);
    pulse(tick);
    pin_is(1'b1);
    put(8'h0a, 8'ha0);
    pin_is(1'b0);
    chk_rd(8'h0f, 8'h44);
    // battery level latched by a requested check on main supply, held between checks
    bkp = 1'b0;
    blow = 1'b1;
    repeat (2) @(negedge clock_i);
    pulse(bchk);
    chk_rd(8'h0f, 8'h14);
    blow = 1'b0;
    chk_rd(8'h0f, 8'h14);
    pulse(bchk);
    chk_rd(8'h0f, 8'h04);
    end_sim();
  end
endmodule // tb
